// ---- rtl/hbfs_defs.svh ----
// Purpose: constants of the half-bridge fault status block
// Assumes: one 16-bit status word, six bridge fields per word
// Notes:   included by the package and the top module
// Overview of operation
// R01: Bit 14 is set while either driver supply is under or over voltage.
// R02: Bit 15 shows a latched overcurrent and bit 13 an underload, one=fault.
// R03: Each bridge has a two-bit field, descending, channel six at bit 12.
// R04: A field reads 00 disabled, 01 overcurrent, 10 underload.
// R05: A field reads 11 when the output is enabled without fault.
// R06: Power-on reset clears every status bit to zero.
// R07: Each field comes from a per-channel priority state machine.
// R08: Supply fault recovers on leaving undervoltage, or overvoltage if lockout.
// R09: The thermal flag is driven before the frame, status after first rise; the code drives the flag ORed with i_si there.
// R10: Underload may move to overcurrent but overcurrent never to underload.
// R11: The status word is captured at frame start and held for the frame.
`ifndef HBFS_DEFS_SVH
`define HBFS_DEFS_SVH
`define HBFS_WORD_W      16
`define HBFS_NUM_CH      6
`define HBFS_BIT_OCS     15
`define HBFS_BIT_PSF     14
`define HBFS_BIT_ULD     13
`define HBFS_BIT_CH_TOP  12
`define HBFS_BIT_TW      0
`define HBFS_CODE_DIS    2'b00
`define HBFS_CODE_OCS    2'b01
`define HBFS_CODE_ULD    2'b10
`define HBFS_CODE_EN     2'b11
`define HBFS_WORD_RST    16'h0000
`endif

// ---- rtl/hbfs_pkg.sv ----
// Purpose: types of the half-bridge fault status block
// Assumes: constants come from hbfs_defs.svh
// Notes:   channel state codes are gray along dis-en-uld-ocs
`include "hbfs_defs.svh"
package hbfs_pkg;
  typedef enum logic [1:0] {
    HBFS_ST_DIS = 2'b00,
    HBFS_ST_EN  = 2'b01,
    HBFS_ST_ULD = 2'b11,
    HBFS_ST_OCS = 2'b10
  } hbfs_ch_st_t;

  typedef struct packed {
    hbfs_ch_st_t [`HBFS_NUM_CH-1:0] ch;
    logic                          supply_fault_flag;
    logic                          ov_lat;
    logic                          thermal_shutdown_flag;
    logic [`HBFS_WORD_W-1:0]       word;
    logic [`HBFS_WORD_W-1:0]       sh;
    logic                          si_lat;
    logic                          pre;
    logic                          so;
    logic                          so_oe_n;
    logic                          sclk;
    logic                          csb_n;
  } hbfs_state_t;
endpackage

// ---- rtl/hbfs_top.sv ----
// Purpose: status word assembly and serial output of a bridge driver
// Assumes: all inputs synchronous to i_core_clk, sclk well below clk/2
// Notes:   fault inputs are levels from the analog monitors
`timescale 1ns/1ps
`include "hbfs_defs.svh"
module hbfs_top #(
  parameter int NUM_CH = `HBFS_NUM_CH
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_csb_n,
  input  wire logic              i_sclk,
  input  wire logic              i_si,
  input  wire logic [NUM_CH-1:0] i_out_enabled,
  input  wire logic [NUM_CH-1:0] i_ocs_det,
  input  wire logic [NUM_CH-1:0] i_uld_det,
  input  wire logic              i_fault_clr,
  input  wire logic              i_vs_uv,
  input  wire logic              i_vs_ov,
  input  wire logic              i_overvoltage_lockout_setting,
  input  wire logic              i_tsd_det,
  input  wire logic              i_tsd_clr,
  input  wire logic              i_thermal_warn,
  output logic                   o_so,
  output logic                   o_so_oe_n,
  output logic [15:0]            o_fault_status_word,
  output logic                   o_thermal_shutdown_flag,
  output logic                   o_supply_fault_flag
);

  if (NUM_CH != `HBFS_NUM_CH) begin : g_bad_num_ch
    $error("hbfs_top: word layout holds exactly six bridge fields");
  end

  hbfs_pkg::hbfs_state_t s_q;
  hbfs_pkg::hbfs_state_t s_d;

  logic                    sclk_rise;
  logic                    sclk_fall;
  logic                    csb_fall;
  logic                    any_ocs;
  logic                    any_uld;
  logic [`HBFS_WORD_W-1:0] live_word;
  logic [2*NUM_CH-1:0]     fields;

  assign sclk_rise = i_sclk & ~s_q.sclk;
  assign sclk_fall = ~i_sclk & s_q.sclk;
  assign csb_fall  = ~i_csb_n & s_q.csb_n;

  // per-channel output code, channel 1 in the lowest field
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_field
      always_comb begin
        unique case (s_q.ch[g])
          hbfs_pkg::HBFS_ST_DIS: fields[2*g +: 2] = `HBFS_CODE_DIS; // [R04]
          hbfs_pkg::HBFS_ST_OCS: fields[2*g +: 2] = `HBFS_CODE_OCS; // [R04]
          hbfs_pkg::HBFS_ST_ULD: fields[2*g +: 2] = `HBFS_CODE_ULD; // [R04]
          hbfs_pkg::HBFS_ST_EN:  fields[2*g +: 2] = `HBFS_CODE_EN;  // [R05]
        endcase
      end
    end
  endgenerate

  always_comb begin
    any_ocs = 1'b0;
    any_uld = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      any_ocs = any_ocs | (s_q.ch[i] == hbfs_pkg::HBFS_ST_OCS);
      any_uld = any_uld | (s_q.ch[i] == hbfs_pkg::HBFS_ST_ULD);
    end
    live_word = `HBFS_WORD_RST;
    live_word[`HBFS_BIT_OCS] = any_ocs;   // [R02]
    live_word[`HBFS_BIT_PSF] = s_q.supply_fault_flag;   // [R01]
    live_word[`HBFS_BIT_ULD] = any_uld;   // [R02]
    // descending packing puts channel six at the top field
    live_word[`HBFS_BIT_CH_TOP -: 2*NUM_CH] = fields; // [R03]
    live_word[`HBFS_BIT_TW] = i_thermal_warn;
  end

  always_comb begin
    s_d = s_q;
    s_d.sclk  = i_sclk;
    s_d.csb_n = i_csb_n;
    s_d.word  = live_word;

    // priority machine per bridge, overcurrent ranks highest
    for (int i = 0; i < NUM_CH; i++) begin
      unique case (s_q.ch[i])
        hbfs_pkg::HBFS_ST_DIS,
        hbfs_pkg::HBFS_ST_EN: begin
          if (i_ocs_det[i]) begin
            s_d.ch[i] = hbfs_pkg::HBFS_ST_OCS; // [R07]
          end else if (i_uld_det[i] && i_out_enabled[i]) begin
            s_d.ch[i] = hbfs_pkg::HBFS_ST_ULD; // [R07]
          end else if (i_out_enabled[i]) begin
            s_d.ch[i] = hbfs_pkg::HBFS_ST_EN;
          end else begin
            s_d.ch[i] = hbfs_pkg::HBFS_ST_DIS;
          end
        end
        hbfs_pkg::HBFS_ST_ULD: begin
          if (i_ocs_det[i]) begin
            s_d.ch[i] = hbfs_pkg::HBFS_ST_OCS; // [R10]
          end else if (!i_uld_det[i] || !i_out_enabled[i]) begin
            s_d.ch[i] = i_out_enabled[i] ? hbfs_pkg::HBFS_ST_EN
                                         : hbfs_pkg::HBFS_ST_DIS;
          end
        end
        hbfs_pkg::HBFS_ST_OCS: begin
          // latched; a new detection in the clear cycle keeps it set
          if (i_fault_clr && !i_ocs_det[i]) begin
            // no direct path to underload from here
            s_d.ch[i] = i_out_enabled[i] ? hbfs_pkg::HBFS_ST_EN
                                         : hbfs_pkg::HBFS_ST_DIS; // [R10]
          end
        end
      endcase
    end

    // without lockout an overvoltage stays flagged until cleared
    if (i_vs_ov) begin
      s_d.ov_lat = 1'b1; // [R01]
    end else if (i_overvoltage_lockout_setting || i_fault_clr) begin
      s_d.ov_lat = 1'b0; // [R08]
    end
    // undervoltage recovers as soon as the supply is back
    s_d.supply_fault_flag = i_vs_uv | s_d.ov_lat; // [R01] [R08]

    if (i_tsd_det) begin
      s_d.thermal_shutdown_flag = 1'b1;
    end else if (i_tsd_clr) begin
      s_d.thermal_shutdown_flag = 1'b0;
    end

    // serial side
    if (i_csb_n) begin
      s_d.so_oe_n = 1'b1;
      s_d.so      = 1'b0;
      s_d.pre     = 1'b0;
    end else if (csb_fall) begin
      s_d.sh      = live_word;            // [R11]
      s_d.pre     = 1'b1;
      s_d.so_oe_n = 1'b0;
      s_d.so      = s_q.thermal_shutdown_flag | i_si;       // [R09]
    end else begin
      s_d.so_oe_n = 1'b0;
      if (sclk_fall) begin
        s_d.si_lat = i_si;
      end
      if (sclk_rise) begin
        s_d.pre = 1'b0;
        s_d.so  = s_q.sh[`HBFS_WORD_W-1]; // [R09]
        s_d.sh  = {s_q.sh[`HBFS_WORD_W-2:0], s_q.si_lat};
      end else if (s_q.pre) begin
        s_d.so  = s_q.thermal_shutdown_flag | i_si;         // [R09]
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      s_q       <= '0; // [R06]
      s_q.csb_n <= 1'b1;
      s_q.so_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_so                    = s_q.so;
  assign o_so_oe_n               = s_q.so_oe_n;
  assign o_fault_status_word     = s_q.word;
  assign o_thermal_shutdown_flag = s_q.thermal_shutdown_flag;
  assign o_supply_fault_flag     = s_q.supply_fault_flag;

endmodule // hbfs_top

// ---- test/hbfs_master.sv ----
// Purpose: serial master model reading one status frame
// Assumes: drives after rising clk edges, samples on falling ones
// Notes: sclk and si rest low between frames, so sclk never runs free
`timescale 1ns/1ps
module hbfs_master (
  input  wire logic i_core_clk,
  input  wire logic i_so,
  output logic      o_csb_n = 1'b1,
  output logic      o_sclk = 1'b0,
  output logic      o_si = 1'b0
);
  task automatic frame(input logic s, output logic p, output logic [15:0] w);
    @(posedge i_core_clk);
    o_csb_n <= 1'b0;
    o_si <= s;
    repeat (2) @(posedge i_core_clk);
    @(negedge i_core_clk) p = i_so;
    // three clocks high and two low per sclk period keeps the two-clock edge spacing
    for (int b = 15; b >= 0; b--) begin
      @(posedge i_core_clk) o_sclk <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk) w[b] = i_so;
      repeat (2) @(posedge i_core_clk) o_sclk <= 1'b0;
    end
    @(posedge i_core_clk);
    o_csb_n <= 1'b1;
    o_si <= 1'b0;
  endtask
endmodule // hbfs_master

// ---- test/hbfs_properties.sv ----
// Purpose: timing checks of the status word and serial output
// Assumes: bound to hbfs_top
// Notes: the word lags its cause by up to two clocks
`timescale 1ns/1ps
module hbfs_chk (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_csb_n,
  input wire logic        i_vs_uv,
  input wire logic        i_vs_ov,
  input wire logic        i_overvoltage_lockout_setting,
  input wire logic [5:0]  i_out_enabled,
  input wire logic [5:0]  i_ocs_det,
  input wire logic [5:0]  i_uld_det,
  input wire logic        o_so,
  input wire logic        o_so_oe_n,
  input wire logic [15:0] o_fault_status_word,
  input wire logic        o_thermal_shutdown_flag
);
  wire logic [15:0] w = o_fault_status_word;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  property p_rst; $fell(i_rst) |-> w == 16'h0000 && o_so_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_psf; i_vs_uv || i_vs_ov |-> ##[1:2] w[14]; endproperty
  a_psf: assert property (p_psf) else $error("psf");
  property p_ocs; i_ocs_det[0] |-> ##[1:2] w[15] && w[2:1] == 2'b01;
  endproperty
  a_ocs: assert property (p_ocs) else $error("ocs");
  property p_dir; w[4:3] == 2'b01 |=> w[4:3] != 2'b10; endproperty
  a_dir: assert property (p_dir) else $error("ocs to uld");
  property p_dis; (!i_out_enabled[5] && !i_ocs_det[5])[*3] ##0
    w[12:11] != 2'b01 |-> w[12:11] == 2'b00; endproperty
  a_dis: assert property (p_dis) else $error("dis");
  property p_en; (i_out_enabled[4] && !i_ocs_det[4] && !i_uld_det[4])[*3]
    ##0 w[10:9] != 2'b01 |-> w[10:9] == 2'b11; endproperty
  a_en: assert property (p_en) else $error("en");
  property p_rec; (!i_vs_uv && !i_vs_ov && i_overvoltage_lockout_setting)[*4]
    |-> !w[14]; endproperty
  a_rec: assert property (p_rec) else $error("psf stuck");
  property p_pre; $fell(i_csb_n) && o_thermal_shutdown_flag |=>
    !o_so_oe_n && o_so; endproperty
  a_pre: assert property (p_pre) else $error("pre bit");
endmodule // hbfs_chk
bind hbfs_top hbfs_chk chk_u (.*);

// ---- test/hbfs_top_tb.sv ----
// Purpose: self-checking bench of the fault status block
// Assumes: master model owns csb, sclk and si
// Notes: scenarios run in order; later ones reuse the enables and underload inputs that t_word leaves
`timescale 1ns/1ps
module hbfs_top_tb;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, i_fault_clr = 1'b0;
  logic        i_csb_n, i_sclk, i_si, o_so, o_so_oe_n, p;
  logic        i_vs_uv = 1'b0, i_vs_ov = 1'b0, i_thermal_warn = 1'b0;
  logic        i_overvoltage_lockout_setting = 1'b0;
  logic        i_tsd_det = 1'b0, i_tsd_clr = 1'b0;
  logic        o_thermal_shutdown_flag, o_supply_fault_flag;
  logic [5:0]  i_out_enabled = 6'h00, i_ocs_det = 6'h00, i_uld_det = 6'h00;
  logic [15:0] o_fault_status_word, f;
  wire  [15:0] w = o_fault_status_word;
  int          fail_count = 0, n_compared = 0;
  always #5 i_core_clk = ~i_core_clk;
  hbfs_top dut_u (.*);
  hbfs_master m_u (.i_core_clk, .i_so(o_so), .o_csb_n(i_csb_n),
                   .o_sclk(i_sclk), .o_si(i_si));
  task chk(input string n, input logic [15:0] s, e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask
  task t_word;
    @(posedge i_core_clk);
    i_out_enabled <= 6'h1F;
    i_uld_det <= 6'h02;
    i_ocs_det <= 6'h01;
    i_tsd_det <= 1'b1;
    @(posedge i_core_clk);
    i_ocs_det <= 6'h00;
    i_tsd_det <= 1'b0;
    cyc(3);
    chk("word", w, 16'hA7F2);
    fork
      m_u.frame(1'b0, p, f);
      // fault arrives mid-frame; the shifted word must not see it
      begin
        repeat (8) @(posedge i_core_clk);
        i_vs_uv <= 1'b1;
      end
    join
    cyc(1);
    chk("pre", 16'(p), 16'h0001);
    chk("frame", f, 16'hA7F2);
    chk("live", w, 16'hE7F2);
  endtask
  task t_prio;
    @(posedge i_core_clk) i_ocs_det <= 6'h02;
    @(posedge i_core_clk) i_ocs_det <= 6'h00;
    cyc(4);
    chk("ch2", 16'(w[4:3]), 16'h0001);
    @(posedge i_core_clk) i_fault_clr <= 1'b1;
    @(posedge i_core_clk) i_fault_clr <= 1'b0;
    cyc(4);
    chk("ch2 ch1", 16'(w[4:1]), 16'h000B);
  endtask
  task t_psf;
    @(posedge i_core_clk) i_vs_uv <= 1'b0;
    cyc(3);
    chk("psf uv", 16'(w[14]), 16'h0000);
    @(posedge i_core_clk) i_vs_ov <= 1'b1;
    @(posedge i_core_clk) i_vs_ov <= 1'b0;
    cyc(3);
    chk("psf ov", 16'(w[14]), 16'h0001);
    chk("psf pin", 16'(o_supply_fault_flag), 16'h0001);
    @(posedge i_core_clk) i_overvoltage_lockout_setting <= 1'b1;
    cyc(3);
    chk("psf", 16'(w[14]), 16'h0000);
  endtask
  task t_thermal;
    @(posedge i_core_clk);
    i_thermal_warn <= 1'b1;
    i_tsd_clr <= 1'b1;
    @(posedge i_core_clk) i_tsd_clr <= 1'b0;
    cyc(2);
    chk("tsd", 16'(o_thermal_shutdown_flag), 16'h0000);
    m_u.frame(1'b1, p, f);
    cyc(1);
    chk("pre si", 16'(p), 16'h0001);
    chk("frame tw", f, 16'h27F7);
  endtask
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    cyc(1);
    chk("reset", {w[15:1], o_so_oe_n}, 16'h0001);
    t_word();
    t_prio();
    t_psf();
    t_thermal();
    end_sim();
  end
  initial begin
    repeat (2000) @(posedge i_core_clk);
    fail_count++;
    end_sim();
  end
endmodule // hbfs_top_tb
